// ---- mem_lane_steer.sv ----
// What this block does
// - 32-bit byte read: strobes 0111/1011/1101/1110 by address; matching lane returned.
// - word write to 8-bit memory: four accesses at 11,10,01,00, each byte on [7:0].
// - halfword write to 8-bit memory: 11 then 10, or 01 then 00.
// - 8-bit byte write uses system address; the single strobe is always active.
// - word write to 16-bit memory: upper half at 1, then lower at 0, strobes 00.
// - 16-bit halfword and byte writes: address bit, strobes 00 for halfword, 01/10 for byte, odd byte high.
// - 32-bit writes pass data; strobes 0000, 0011/1100, 0111/1011/1101/1110 by size.
`timescale 1ns/1ns
`default_nettype none
module mem_lane_steer
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic        req_write_i,
    input  wire logic [2:0]  req_size_i,
    input  wire logic [1:0]  req_addr_i,
    input  wire logic [31:0] req_wdata_i,
    input  wire logic [1:0]  mem_width_i,
    output logic             ext_valid_o,
    input  wire logic        ext_ready_i,
    output logic             ext_write_o,
    output logic      [1:0]  external_addr_low_o,
    output logic      [3:0]  byte_lane_strobe_n_o,
    output logic      [31:0] ext_wdata_o,
    input  wire logic [31:0] ext_rdata_i,
    output logic             resp_valid_o,
    output logic             resp_write_o,
    output logic      [31:0] resp_rdata_o
);
    typedef struct packed {
        mem_steer_pkg::state_type state;
        logic                     write;
        logic [2:0]               size;
        logic [1:0]               addr;
        logic [1:0]               width;
        logic [31:0]              wdata;
        logic [1:0]               beat;
        logic [1:0]               last;
        logic [1:0]               addr_low;
        logic [3:0]               strobe_n;
        logic [31:0]              ext_wdata;
        logic [31:0]              rdata;
    } steer_type;

    localparam steer_type RESET_STATE = '{state: mem_steer_pkg::ST_IDLE,
                                          strobe_n: mem_steer_pkg::STB_NONE,
                                          default: '0};

    steer_type steer_q;
    steer_type steer_d;
    logic      f_valid;
    logic      f_pop;
    logic [mem_steer_pkg::REQ_W-1:0] f_data;
    logic [5:0] map;

    // number of external accesses, minus one
    function automatic logic [1:0] last_beat(input logic [1:0] width, input logic [2:0] size);
        logic [1:0] r;
        r = mem_steer_pkg::LAST_OF_1;
        if (width == mem_steer_pkg::WIDTH_8)
        begin
            if (size == mem_steer_pkg::SIZE_HALF) r = mem_steer_pkg::LAST_OF_2;
            else if (size != mem_steer_pkg::SIZE_BYTE) r = mem_steer_pkg::LAST_OF_4;
        end
        else if (width == mem_steer_pkg::WIDTH_16 && size != mem_steer_pkg::SIZE_BYTE
                 && size != mem_steer_pkg::SIZE_HALF)
        begin
            r = mem_steer_pkg::LAST_OF_2;
        end
        return r;
    endfunction

    // low external address and strobes of one access
    function automatic logic [5:0] beat_map(input logic [1:0] width, input logic [2:0] size,
                                            input logic [1:0] addr, input logic [1:0] beat);
        logic [1:0] a;
        logic [3:0] s;
        a = addr;
        s = mem_steer_pkg::STB_WORD;
        if (width == mem_steer_pkg::WIDTH_8)
        begin
            s = mem_steer_pkg::STB8_LANE0;
            if (size == mem_steer_pkg::SIZE_HALF) a = {addr[1], ~beat[0]};
            else if (size != mem_steer_pkg::SIZE_BYTE) a = ~beat;
        end
        else if (width == mem_steer_pkg::WIDTH_16)
        begin
            s = mem_steer_pkg::STB16_HALF;
            a = {1'b0, addr[1]};
            if (size == mem_steer_pkg::SIZE_BYTE)
                s = addr[0] ? mem_steer_pkg::STB16_HI_BYTE : mem_steer_pkg::STB16_LO_BYTE;
            else if (size != mem_steer_pkg::SIZE_HALF)
                a = {1'b0, ~beat[0]};
        end
        else if (size == mem_steer_pkg::SIZE_HALF)
        begin
            s = addr[1] ? mem_steer_pkg::STB_HALF_HI : mem_steer_pkg::STB_HALF_LO;
        end
        else if (size == mem_steer_pkg::SIZE_BYTE)
        begin
            s = ~(mem_steer_pkg::STB_LANE_ONE << addr);
        end
        return {a, s};
    endfunction

    // system data placed on the external lanes
    function automatic logic [31:0] beat_wdata(input logic [1:0] width, input logic [1:0] a,
                                               input logic [31:0] wdata);
        logic [31:0] sh;
        sh = wdata;
        if (width == mem_steer_pkg::WIDTH_8)
            sh = {24'h000000, 8'(wdata >> {a, 3'h0})};
        else if (width == mem_steer_pkg::WIDTH_16)
            sh = {16'h0000, 16'(wdata >> {a[0], 4'h0})};
        return sh;
    endfunction

    // external data merged into the system read word
    function automatic logic [31:0] merge_rdata(input logic [1:0] width, input logic [1:0] a,
                                                input logic [31:0] acc, input logic [31:0] ext);
        logic [31:0] r;
        r = acc;
        for (int i = 0; i < 4; i++)
        begin
            if (width == mem_steer_pkg::WIDTH_8 && a == 2'(i))
                r[i*8 +: 8] = ext[7:0];
        end
        for (int i = 0; i < 2; i++)
        begin
            if (width == mem_steer_pkg::WIDTH_16 && a[0] == 1'(i))
                r[i*16 +: 16] = ext[15:0];
        end
        if (width != mem_steer_pkg::WIDTH_8 && width != mem_steer_pkg::WIDTH_16)
            r = ext;
        return r;
    endfunction

    // request queue; engine stalls hold it full and push back on the source
    steer_fifo #(
        .WIDTH (mem_steer_pkg::REQ_W),
        .DEPTH (mem_steer_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (req_valid_i),
        .in_ready_o  (req_ready_o),
        .in_data_i   ({req_write_i, req_size_i, req_addr_i, mem_width_i, req_wdata_i}),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop),
        .out_data_o  (f_data)
    );

    // outputs straight from the state register
    assign f_pop                = (steer_q.state == mem_steer_pkg::ST_IDLE);
    assign ext_valid_o          = (steer_q.state == mem_steer_pkg::ST_RUN);
    assign ext_write_o          = steer_q.write;
    assign external_addr_low_o  = steer_q.addr_low;
    assign byte_lane_strobe_n_o = steer_q.strobe_n;
    assign ext_wdata_o          = steer_q.ext_wdata;
    assign resp_valid_o         = (steer_q.state == mem_steer_pkg::ST_RESP);
    assign resp_write_o         = steer_q.write;
    assign resp_rdata_o         = steer_q.rdata;

    // sequencer: take a request, walk its accesses, then answer
    always_comb
    begin
        steer_d = steer_q;
        map     = '0;
        unique case (steer_q.state)
            mem_steer_pkg::ST_IDLE:
            begin
                if (f_valid)
                begin
                    {steer_d.write, steer_d.size, steer_d.addr, steer_d.width,
                     steer_d.wdata} = f_data;
                    steer_d.state = mem_steer_pkg::ST_RUN;
                    steer_d.beat  = '0;
                    steer_d.last  = last_beat(steer_d.width, steer_d.size);
                    steer_d.rdata = '0;
                end
            end
            mem_steer_pkg::ST_RUN:
            begin
                if (ext_ready_i)
                begin
                    if (!steer_q.write)
                        steer_d.rdata = merge_rdata(steer_q.width, steer_q.addr_low,
                                                    steer_q.rdata, ext_rdata_i);
                    if (steer_q.beat == steer_q.last)
                        steer_d.state = mem_steer_pkg::ST_RESP;
                    else
                        steer_d.beat = 2'(steer_q.beat + 1'b1);
                end
            end
            mem_steer_pkg::ST_RESP:
            begin
                steer_d.state = mem_steer_pkg::ST_IDLE;
            end
        endcase
        // present the current access, or idle strobes
        if (steer_d.state == mem_steer_pkg::ST_RUN)
        begin
            map               = beat_map(steer_d.width, steer_d.size, steer_d.addr, steer_d.beat);
            steer_d.addr_low  = map[5:4];
            steer_d.strobe_n  = map[3:0];
            steer_d.ext_wdata = beat_wdata(steer_d.width, map[5:4], steer_d.wdata);
        end
        else
        begin
            steer_d.strobe_n = mem_steer_pkg::STB_NONE;
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            steer_q <= RESET_STATE;
        end
        else
        begin
            steer_q <= steer_d;
        end
    end

    // shorthands for the checks
    logic run8;
    logic run16;
    logic run32;
    assign run8  = ext_valid_o && steer_q.width == mem_steer_pkg::WIDTH_8;
    assign run16 = ext_valid_o && steer_q.width == mem_steer_pkg::WIDTH_16;
    assign run32 = ext_valid_o && steer_q.width != mem_steer_pkg::WIDTH_8
                   && steer_q.width != mem_steer_pkg::WIDTH_16;

    sequence s_last_taken;
        ext_valid_o && ext_ready_i && steer_q.beat == steer_q.last;
    endsequence

    a_byte_read_strobe: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run32 && !ext_write_o && steer_q.size == mem_steer_pkg::SIZE_BYTE
        |-> byte_lane_strobe_n_o == ~(4'h1 << steer_q.addr))
        else $error("32-bit byte read strobe wrong");

    a_word8_order: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run8 && steer_q.size == mem_steer_pkg::SIZE_WORD
        |-> external_addr_low_o == ~steer_q.beat
            && ext_wdata_o[7:0] == steer_q.wdata[{external_addr_low_o, 3'h0} +: 8])
        else $error("8-bit word write access order wrong");

    a_half8_pair: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run8 && steer_q.size == mem_steer_pkg::SIZE_HALF && steer_q.beat == 2'h0 && ext_ready_i
        |=> external_addr_low_o == {steer_q.addr[1], 1'b0} && steer_q.beat == 2'h1)
        else $error("8-bit halfword second access wrong");

    a_strobe8_active: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run8 |-> !byte_lane_strobe_n_o[0]
        && (steer_q.size != mem_steer_pkg::SIZE_BYTE || external_addr_low_o == steer_q.addr))
        else $error("8-bit strobe or byte address wrong");

    a_word16_halves: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run16 && steer_q.size == mem_steer_pkg::SIZE_WORD && steer_q.beat == 2'h0
        |-> external_addr_low_o[0] && ext_wdata_o[15:0] == steer_q.wdata[31:16]
            && byte_lane_strobe_n_o[1:0] == 2'h0)
        else $error("16-bit word first access wrong");

    a_byte16_strobe: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run16 && steer_q.size == mem_steer_pkg::SIZE_BYTE
        |-> byte_lane_strobe_n_o[1:0] == (steer_q.addr[0] ? 2'h1 : 2'h2)
            && external_addr_low_o[0] == steer_q.addr[1])
        else $error("16-bit byte strobe wrong");

    a_write32_pass: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run32 && ext_write_o |-> ext_wdata_o == steer_q.wdata
        && (steer_q.size != mem_steer_pkg::SIZE_WORD || byte_lane_strobe_n_o == 4'h0))
        else $error("32-bit write data or strobe wrong");

    a_resp_after_last: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        resp_valid_o |-> $past(ext_valid_o && ext_ready_i && steer_q.beat == steer_q.last))
        else $error("answer without final access");

    a_last_then_resp: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_last_taken |=> resp_valid_o ##1 !resp_valid_o)
        else $error("final access not answered once");
endmodule // mem_lane_steer
`default_nettype wire

// ---- mem_steer_pkg.sv ----
`default_nettype none
package mem_steer_pkg;
    // transfer size codes on the system bus
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    // external memory width codes
    localparam logic [1:0] WIDTH_8   = 2'h0;
    localparam logic [1:0] WIDTH_16  = 2'h1;
    localparam logic [1:0] WIDTH_32  = 2'h2;
    // active-low byte-lane strobe patterns, unused lanes held high
    localparam logic [3:0] STB_NONE      = 4'hF;
    localparam logic [3:0] STB_WORD      = 4'h0;
    localparam logic [3:0] STB_HALF_HI   = 4'h3;
    localparam logic [3:0] STB_HALF_LO   = 4'hC;
    localparam logic [3:0] STB_LANE_ONE  = 4'h1;
    localparam logic [3:0] STB8_LANE0    = 4'hE;
    localparam logic [3:0] STB16_HALF    = 4'hC;
    localparam logic [3:0] STB16_HI_BYTE = 4'hD;
    localparam logic [3:0] STB16_LO_BYTE = 4'hE;
    // index of the last external access of a split transfer
    localparam logic [1:0] LAST_OF_4 = 2'h3;
    localparam logic [1:0] LAST_OF_2 = 2'h1;
    localparam logic [1:0] LAST_OF_1 = 2'h0;
    // request word: write, size, addr, width, wdata
    localparam int REQ_W      = 40;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RESP} state_type;
endpackage
`default_nettype wire

// ---- steer_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module steer_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        out_valid;
        logic [WIDTH-1:0]            out_data;
    } fifo_type;

    fifo_type fifo_q;
    fifo_type fifo_d;
    logic     push;
    logic     load;

    // handshakes; head register refills when empty or drained
    assign in_ready_o  = (fifo_q.count != FULL_COUNT);
    assign out_valid_o = fifo_q.out_valid;
    assign out_data_o  = fifo_q.out_data;
    assign push        = in_valid_i && in_ready_o;
    assign load        = (fifo_q.count != '0) && (!fifo_q.out_valid || out_ready_i);

    // next state of storage, pointers and head register
    always_comb
    begin
        fifo_d = fifo_q;
        if (fifo_q.out_valid && out_ready_i)
        begin
            fifo_d.out_valid = 1'b0;
        end
        if (load)
        begin
            fifo_d.out_data  = fifo_q.mem[fifo_q.rd_ptr];
            fifo_d.out_valid = 1'b1;
            fifo_d.rd_ptr    = PW'(fifo_q.rd_ptr + 1'b1);
        end
        if (push)
        begin
            fifo_d.mem[fifo_q.wr_ptr] = in_data_i;
            fifo_d.wr_ptr             = PW'(fifo_q.wr_ptr + 1'b1);
        end
        if (push && !load)
        begin
            fifo_d.count = CW'(fifo_q.count + 1'b1);
        end
        else if (load && !push)
        begin
            fifo_d.count = CW'(fifo_q.count - 1'b1);
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            fifo_q <= '0;
        end
        else
        begin
            fifo_q <= fifo_d;
        end
    end
endmodule // steer_fifo
`default_nettype wire

// ---- ext_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        valid_i,
    input  wire logic        stall_i,
    input  wire logic [1:0]  wait_i,
    output logic             ready_o,
    output logic      [31:0] rdata_o
);
    logic [1:0]  wait_q;
    logic [7:0]  seq_q;
    logic [31:0] last_q;
    // access ends once the set wait has passed, never while stalled
    assign ready_o = valid_i && !stall_i && (wait_q >= wait_i);
    // new pattern per access; bus shows inverse of last value when idle
    assign rdata_o = ready_o ? (32'h8C4A2E17 ^ {4{seq_q}}) : ~last_q;
    // wait counter, saturating while stalled
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || !valid_i || ready_o)
        begin
            wait_q <= 2'h0;
        end
        else if (wait_q != 2'h3)
        begin
            wait_q <= wait_q + 2'h1;
        end
    end
    // access sequence and last driven value
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            seq_q  <= 8'h0;
            last_q <= 32'h0;
        end
        else if (ready_o)
        begin
            seq_q  <= seq_q + 8'h1;
            last_q <= rdata_o;
        end
    end
endmodule // ext_mem_model
`default_nettype wire

// ---- test_memory_byte_lane_steering.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_memory_byte_lane_steering;
    logic        clk_i, reset_n_i, req_valid_i, req_ready_o, req_write_i;
    logic [2:0]  req_size_i;
    logic [1:0]  req_addr_i, mem_width_i, external_addr_low_o, mem_wait;
    logic [31:0] req_wdata_i, ext_wdata_o, ext_rdata_i, resp_rdata_o;
    logic        ext_valid_o, ext_ready_i, ext_write_o, resp_valid_o, resp_write_o, stall;
    logic [3:0]  byte_lane_strobe_n_o;
    logic [1:0]  l_ad[$];
    logic [3:0]  l_st[$];
    logic [31:0] l_wd[$], l_rd[$];
    logic        l_wr[$];
    int          miscompares, comparisons;
    mem_lane_steer uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_size_i(req_size_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .mem_width_i(mem_width_i),
        .ext_valid_o(ext_valid_o), .ext_ready_i(ext_ready_i), .ext_write_o(ext_write_o),
        .external_addr_low_o(external_addr_low_o), .byte_lane_strobe_n_o(byte_lane_strobe_n_o),
        .ext_wdata_o(ext_wdata_o), .ext_rdata_i(ext_rdata_i), .resp_valid_o(resp_valid_o),
        .resp_write_o(resp_write_o), .resp_rdata_o(resp_rdata_o));
    ext_mem_model mem (.clk_i(clk_i), .reset_n_i(reset_n_i), .valid_i(ext_valid_o),
        .stall_i(stall), .wait_i(mem_wait), .ready_o(ext_ready_i), .rdata_o(ext_rdata_i));
    // clock generation
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // log every finished external access
    always @(posedge clk_i)
    begin
        if (reset_n_i && ext_valid_o && ext_ready_i)
        begin
            l_ad.push_back(external_addr_low_o);
            l_st.push_back(byte_lane_strobe_n_o);
            l_wd.push_back(ext_wdata_o);
            l_rd.push_back(ext_rdata_i);
            l_wr.push_back(ext_write_o);
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic clear_log();
        l_ad.delete();
        l_st.delete();
        l_wd.delete();
        l_rd.delete();
        l_wr.delete();
    endtask
    // one transfer, checked access by access against the lane map
    task automatic xfer(input logic wr, input logic [2:0] sz, input logic [1:0] ad,
                        input logic [31:0] wd, input logic [1:0] wid);
        int          n, k;
        logic [1:0]  ea;
        logic [3:0]  es;
        logic [31:0] ed, er, msk;
        clear_log();
        n = (wid == 2'h0) ? (sz == 3'h2 ? 4 : (sz == 3'h1 ? 2 : 1)) :
            ((wid == 2'h1 && sz == 3'h2) ? 2 : 1);
        er = 32'h0;
        req_write_i <= wr;
        req_size_i  <= sz;
        req_addr_i  <= ad;
        req_wdata_i <= wd;
        mem_width_i <= wid;
        req_valid_i <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(negedge clk_i);
            ea[0] = req_ready_o;
            @(posedge clk_i);
            if (ea[0] === 1'b1)
                break;
        end
        req_valid_i <= 1'b0;
        for (k = 0; k < 200 && resp_valid_o !== 1'b1; k++)
            @(negedge clk_i);
        if (resp_valid_o !== 1'b1)
        begin
            chk("response timeout", 32'h1, 32'h0);
            summarize();
        end
        chk("access count", n, l_ad.size());
        chk("resp write", {31'h0, wr}, {31'h0, resp_write_o});
        for (k = 0; k < n && k < l_ad.size(); k++)
        begin
            case (wid)
                mem_steer_pkg::WIDTH_8:
                begin
                    ea = (sz == 3'h2) ? 2'(3 - k) : ((sz == 3'h1) ? {ad[1], ~k[0]} : ad);
                    es = 4'hE;
                    ed = {24'h0, wd[8*ea +: 8]};
                    er[8*ea +: 8] = l_rd[k][7:0];
                end
                mem_steer_pkg::WIDTH_16:
                begin
                    ea = {1'b0, (sz == 3'h2) ? (k == 0) : ad[1]};
                    es = (sz == 3'h0) ? (ad[0] ? 4'hD : 4'hE) : 4'hC;
                    ed = {16'h0, wd[16*ea[0] +: 16]};
                    er[16*ea[0] +: 16] = l_rd[k][15:0];
                end
                default:
                begin
                    ea = ad;
                    es = (sz == 3'h0) ? ~(4'h1 << ad) :
                         ((sz == 3'h1) ? (ad[1] ? 4'h3 : 4'hC) : 4'h0);
                    ed = wd;
                    er = l_rd[k];
                end
            endcase
            msk = {{8{~es[3]}}, {8{~es[2]}}, {8{~es[1]}}, {8{~es[0]}}};
            chk("ext addr", {30'h0, ea}, {30'h0, l_ad[k]});
            chk("strobes", {28'h0, es}, {28'h0, l_st[k]});
            chk("ext write", {31'h0, wr}, {31'h0, l_wr[k]});
            if (wr)
                chk("ext wdata", ed & msk, l_wd[k] & msk);
        end
        msk = (sz == 3'h0) ? (32'hFF << (8 * ad)) :
              ((sz == 3'h1) ? (ad[1] ? 32'hFFFF0000 : 32'h0000FFFF) : 32'hFFFFFFFF);
        if (!wr)
            chk("read data", er & msk, resp_rdata_o & msk);
        @(posedge clk_i);
    endtask
    // every size and address, writes then reads, one memory width
    task automatic s_all_sizes(input logic [1:0] wid);
        for (int s = 0; s < 3; s++)
            for (int a = 0; a < 4; a++)
            begin
                xfer(1'b1, 3'(s), 2'(a), 32'hA1B2C3D4 ^ (32'h01010101 * a), wid);
                xfer(1'b0, 3'(s), 2'(a), 32'h0, wid);
            end
    endtask
    // slow memory: no response before every access is done
    task automatic s_slow_memory();
        mem_wait <= 2'h2;
        xfer(1'b0, 3'h2, 2'h0, 32'h0, mem_steer_pkg::WIDTH_8);
        xfer(1'b1, 3'h2, 2'h0, 32'h5A6B7C8D, mem_steer_pkg::WIDTH_16);
        xfer(1'b1, 3'h3, 2'h2, 32'h13572468, 2'h3);
        xfer(1'b0, 3'h3, 2'h1, 32'h0, 2'h3);
        mem_wait <= 2'h0;
    endtask
    // fill the queue against a stalled memory, then drain in order
    task automatic s_fill_drain();
        int acc, got, k;
        clear_log();
        acc = 0;
        got = 0;
        stall       <= 1'b1;
        req_write_i <= 1'b1;
        req_size_i  <= 3'h2;
        mem_width_i <= mem_steer_pkg::WIDTH_32;
        req_wdata_i <= 32'h0;
        req_valid_i <= 1'b1;
        for (k = 0; k < 8; k++)
        begin
            @(negedge clk_i);
            if (req_ready_o !== 1'b1)
                break;
            @(posedge clk_i);
            acc++;
            req_wdata_i <= 32'(acc);
        end
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        stall       <= 1'b0;
        chk("queue capacity", 32'h6, 32'(acc));
        for (k = 0; k < 100 && got < 6; k++)
        begin
            @(negedge clk_i);
            if (resp_valid_o === 1'b1)
                got++;
        end
        chk("drained responses", 32'h6, 32'(got));
        for (k = 0; k < 6 && k < l_wd.size(); k++)
            chk("drain order", 32'(k), l_wd[k]);
        @(posedge clk_i);
    endtask
    // main sequence
    initial
    begin
        miscompares = 0;
        comparisons = 0;
        reset_n_i   = 1'b0;
        req_valid_i = 1'b0;
        req_write_i = 1'b0;
        req_size_i  = 3'h0;
        req_addr_i  = 2'h0;
        req_wdata_i = 32'h0;
        mem_width_i = 2'h0;
        mem_wait    = 2'h0;
        stall       = 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        s_all_sizes(mem_steer_pkg::WIDTH_8);
        s_all_sizes(mem_steer_pkg::WIDTH_16);
        s_all_sizes(mem_steer_pkg::WIDTH_32);
        s_slow_memory();
        s_fill_drain();
        summarize();
    end
endmodule // test_memory_byte_lane_steering
`default_nettype wire
